// file: verilog/dpg_map.vh
// Purpose: constants for the digital port group control block
// Assumes: one clock, synchronous inputs
// Notes:   setup code bit order follows the port order of the direction code
`ifndef DPG_MAP_VH
`define DPG_MAP_VH
// setup code bits, 1 = input
`define DPG_DIR_FIRST      3
`define DPG_DIR_SPLIT_HI   2
`define DPG_DIR_SECOND     1
`define DPG_DIR_SPLIT_LO   0
`define DPG_DIR_ALL_IN     4'hf
// port select codes, anything else picks the split port
`define DPG_SEL_FIRST      2'h0
`define DPG_SEL_SECOND     2'h1
// interrupt configuration fields
`define DPG_IRQ1_LSB       0
`define DPG_IRQ2_LSB       2
`define DPG_IRQ_OFF        2'h0
`define DPG_IRQ_MODE1      2'h1
`define DPG_IRQ_MODE2      2'h2
`define DPG_IRQ_MODE3      2'h3
// counter modes
`define DPG_CM_TERMINAL    3'h0
`define DPG_CM_ONESHOT     3'h1
`define DPG_CM_RATE        3'h2
`define DPG_CM_SQUARE      3'h3
`define DPG_CM_SWSTROBE    3'h4
`define DPG_CM_HWSTROBE    3'h5
`endif

// file: verilog/dpg_down_counter.v
// Purpose: 16-bit loadable down counter with six modes
// Assumes: tick is a one-cycle enable
// Notes:   reload modes wrap to the loaded value
`timescale 1ns/1ns
`default_nettype none
`include "dpg_map.vh"
module dpg_down_counter #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // control
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  input  wire [2:0]       mode,
  input  wire             run,
  input  wire             tick,
  // state
  output reg  [WIDTH-1:0] count_ff,
  output reg              outLevel_ff,
  output reg              pulse_ff
);
  reg [WIDTH-1:0] reload_ff;
  reg [2:0]       mode_ff;
  reg             armed_ff;
  wire            atOne   = (count_ff == {{(WIDTH-1){1'b0}}, 1'b1});
  wire            reloads = (mode_ff == `DPG_CM_RATE) || (mode_ff == `DPG_CM_SQUARE);
  wire            half    = (count_ff == {1'b0, reload_ff[WIDTH-1:1]});

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff    <= {WIDTH{1'b0}};
      reload_ff   <= {WIDTH{1'b0}};
      mode_ff     <= 3'h0;
      armed_ff    <= 1'b0;
      outLevel_ff <= 1'b0;
      pulse_ff    <= 1'b0;
    end else begin
      pulse_ff <= 1'b0;
      if (load) begin
        count_ff    <= loadValue;
        reload_ff   <= loadValue;
        mode_ff     <= mode;
        armed_ff    <= 1'b1;
        outLevel_ff <= (mode == `DPG_CM_RATE) || (mode == `DPG_CM_SQUARE);
      end else if (run && tick && armed_ff) begin
        if (atOne) begin
          pulse_ff <= 1'b1;
          if (reloads) begin
            count_ff <= reload_ff;
            outLevel_ff <= 1'b1;
          end else begin
            count_ff    <= count_ff - 1'b1;
            armed_ff    <= 1'b0;
            outLevel_ff <= 1'b1;
          end
        end else begin
          count_ff <= count_ff - 1'b1;
          if (mode_ff == `DPG_CM_SQUARE && half)
            outLevel_ff <= 1'b0;
        end
      end
    end
  end
endmodule // dpg_down_counter
`default_nettype wire

// file: verilog/dpg_port_group.v
// Purpose: one group of digital ports with directions, interrupts and counters
// Assumes: host strobes are one-cycle pulses synchronous to ref_clk
// Notes:   software reset touches port directions only
`timescale 1ns/1ns
`default_nettype none
`include "dpg_map.vh"
//==================================================================
// Contract
// - four-bit setup code sets directions of four ports independently
// - interrupt configuration holds two 2-bit mode fields
// - general counter loads count, takes one of six modes, starts counting
// - present general count readable while running without disturbing it
// - stopping freezes general counter and reports held count
// - chained counters, own divisors, started together by host
// - one readable flag per interrupt source, 1 when requested
// - host clear action drops pending interrupt requests
// - software reset returns every port to input
// - software reset leaves all other settings unchanged
// - chained counters set second source request rate in timer mode
// - data bits 7..0 map to port lines 7..0
module dpg_port_group #(
  parameter CW = 16
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          rst,
  // direction setup
  input  wire          setupWr,
  input  wire [3:0]    setupCode,
  input  wire          softReset,
  output reg  [3:0]    dirIn_ff,
  // port data
  input  wire          portWr,
  input  wire [1:0]    portSel,
  input  wire [7:0]    portWrData,
  output reg  [7:0]    portRdData_ff,
  input  wire [7:0]    firstPortIn,
  input  wire [7:0]    secondPortIn,
  input  wire [7:0]    splitPortIn,
  output reg  [7:0]    firstPortOut_ff,
  output reg  [7:0]    secondPortOut_ff,
  output reg  [7:0]    splitPortOut_ff,
  output wire [7:0]    firstPortOe,
  output wire [7:0]    secondPortOe,
  output wire [7:0]    splitPortOe,
  // interrupts
  input  wire          irqCfgWr,
  input  wire [3:0]    irqCfg,
  input  wire          irqClear,
  input  wire          firstEventIn,
  input  wire          secondEventIn,
  output reg           firstIrqFlag_ff,
  output reg           secondIrqFlag_ff,
  output wire          irqReq,
  // general counter
  input  wire          genLoad,
  input  wire [2:0]    genMode,
  input  wire [CW-1:0] genValue,
  input  wire          genStop,
  input  wire          genTick,
  output wire [CW-1:0] genCount,
  output wire          genOut,
  // chained counters
  input  wire          chainStart,
  input  wire [CW-1:0] chainDivisorLo,
  input  wire [CW-1:0] chainDivisorHi,
  input  wire          chainTick,
  output wire          chainOut
);
  reg  [3:0]    irqCfg_ff;
  reg           genRun_ff;
  reg           firstEvPrev_ff;
  reg           secondEvPrev_ff;
  wire          loPulse;
  wire          hiPulse;
  wire          genPulse;
  wire [1:0]    irq1Mode = irqCfg_ff[`DPG_IRQ1_LSB +: 2];
  wire [1:0]    irq2Mode = irqCfg_ff[`DPG_IRQ2_LSB +: 2];
  reg           irq1Hit;
  reg           irq2Hit;

  // output enable low means driven
  function [7:0] oeOf(input isIn);
    oeOf = {8{isIn}};
  endfunction

  function srcHit(input [1:0] m, input lvl, input prev, input alt);
    case (m)
      `DPG_IRQ_MODE1: srcHit = lvl & ~prev;
      `DPG_IRQ_MODE2: srcHit = ~lvl & prev;
      `DPG_IRQ_MODE3: srcHit = alt;
      default:        srcHit = 1'b0;
    endcase
  endfunction

  //==================================================================
  // directions and data
  assign firstPortOe  = oeOf(dirIn_ff[`DPG_DIR_FIRST]);
  assign secondPortOe = oeOf(dirIn_ff[`DPG_DIR_SECOND]);
  // each nibble of the split port follows its own direction bit
  assign splitPortOe  = {{4{dirIn_ff[`DPG_DIR_SPLIT_HI]}}, {4{dirIn_ff[`DPG_DIR_SPLIT_LO]}}};

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dirIn_ff         <= `DPG_DIR_ALL_IN;
      firstPortOut_ff  <= 8'h00;
      secondPortOut_ff <= 8'h00;
      splitPortOut_ff  <= 8'h00;
      portRdData_ff    <= 8'h00;
    end else begin
      // soft reset wins; it alters nothing but directions
      if (softReset)
        dirIn_ff <= `DPG_DIR_ALL_IN;
      else if (setupWr)
        dirIn_ff <= setupCode;
      if (portWr) begin
        case (portSel)
          `DPG_SEL_FIRST:  firstPortOut_ff  <= portWrData;
          `DPG_SEL_SECOND: secondPortOut_ff <= portWrData;
          default: splitPortOut_ff  <= portWrData;
        endcase
      end
      // input lines read back live, output lines read the latch
      case (portSel)
        `DPG_SEL_FIRST:  portRdData_ff <= dirIn_ff[`DPG_DIR_FIRST] ? firstPortIn : firstPortOut_ff;
        `DPG_SEL_SECOND: portRdData_ff <= dirIn_ff[`DPG_DIR_SECOND] ? secondPortIn : secondPortOut_ff;
        default: portRdData_ff <= {dirIn_ff[`DPG_DIR_SPLIT_HI] ? splitPortIn[7:4] : splitPortOut_ff[7:4],
                                   dirIn_ff[`DPG_DIR_SPLIT_LO] ? splitPortIn[3:0] : splitPortOut_ff[3:0]};
      endcase
    end
  end

  //==================================================================
  // interrupts
  always @* begin
    irq1Hit = srcHit(irq1Mode, firstEventIn, firstEvPrev_ff, genPulse);
    irq2Hit = srcHit(irq2Mode, secondEventIn, secondEvPrev_ff, hiPulse);
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqCfg_ff        <= 4'h0;
      firstEvPrev_ff   <= 1'b0;
      secondEvPrev_ff  <= 1'b0;
      firstIrqFlag_ff  <= 1'b0;
      secondIrqFlag_ff <= 1'b0;
    end else begin
      firstEvPrev_ff  <= firstEventIn;
      secondEvPrev_ff <= secondEventIn;
      if (irqCfgWr)
        irqCfg_ff <= irqCfg;
      // a new request in the clear cycle survives
      if (irq1Hit)
        firstIrqFlag_ff <= 1'b1;
      else if (irqClear)
        firstIrqFlag_ff <= 1'b0;
      if (irq2Hit)
        secondIrqFlag_ff <= 1'b1;
      else if (irqClear)
        secondIrqFlag_ff <= 1'b0;
    end
  end
  assign irqReq = firstIrqFlag_ff | secondIrqFlag_ff;

  //==================================================================
  // general counter
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      genRun_ff <= 1'b0;
    else if (genLoad)
      genRun_ff <= 1'b1;
    else if (genStop)
      genRun_ff <= 1'b0;
  end

  // count is read straight from the flops, no latch pulse needed
  dpg_down_counter #(.WIDTH(CW)) genCounter (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .load        (genLoad),
    .loadValue   (genValue),
    .mode        (genMode),
    .run         (genRun_ff & ~genStop),
    .tick        (genTick),
    .count_ff    (genCount),
    .outLevel_ff (genOut),
    .pulse_ff    (genPulse)
  );

  //==================================================================
  // chained counters: low stage clocks the high stage
  dpg_down_counter #(.WIDTH(CW)) chainLo (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .load        (chainStart),
    .loadValue   (chainDivisorLo),
    .mode        (`DPG_CM_RATE),
    .run         (1'b1),
    .tick        (chainTick),
    .count_ff    (),
    .outLevel_ff (),
    .pulse_ff    (loPulse)
  );

  dpg_down_counter #(.WIDTH(CW)) chainHi (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .load        (chainStart),
    .loadValue   (chainDivisorHi),
    .mode        (`DPG_CM_RATE),
    .run         (1'b1),
    .tick        (loPulse),
    .count_ff    (),
    .outLevel_ff (chainOut),
    .pulse_ff    (hiPulse)
  );
endmodule // dpg_port_group
`default_nettype wire

// file: tb/dpg_group_assertions.sv
// Purpose: port-level checks for the port group
// Assumes: bound to every dpg_port_group
// Notes:   keeps its own copy of the irq setup
`timescale 1ns/1ns
`default_nettype none
module dpg_group_assertions #(
  parameter CW = 16
) (
  // ==========================================
  // watched ports
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          setupWr,
  input wire logic [3:0]    setupCode,
  input wire logic          softReset,
  input wire logic [3:0]    dirIn_ff,
  input wire logic          portWr,
  input wire logic [1:0]    portSel,
  input wire logic [7:0]    portWrData,
  input wire logic [7:0]    firstPortOut_ff,
  input wire logic [7:0]    firstPortOe,
  input wire logic [7:0]    splitPortOe,
  input wire logic          irqCfgWr,
  input wire logic [3:0]    irqCfg,
  input wire logic          irqClear,
  input wire logic          firstEventIn,
  input wire logic          firstIrqFlag_ff,
  input wire logic          secondIrqFlag_ff,
  input wire logic          irqReq,
  input wire logic          genLoad,
  input wire logic [CW-1:0] genValue,
  input wire logic          genStop,
  input wire logic [CW-1:0] genCount
);
  logic [3:0] cfg_ff;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) cfg_ff <= 4'h0;
    else if (irqCfgWr) cfg_ff <= irqCfg;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_setup_load: assert property (setupWr && !softReset |=> dirIn_ff == $past(setupCode))
    else $error("setup code not taken");
  a_soft_all_in: assert property (softReset |=> dirIn_ff == 4'hf)
    else $error("soft reset left an output");
  a_oe_follow: assert property (firstPortOe == {8{dirIn_ff[3]}} && splitPortOe == {{4{dirIn_ff[2]}}, {4{dirIn_ff[0]}}})
    else $error("enable does not match direction");
  a_latch_bits: assert property (portWr && portSel == 2'h0 |=> firstPortOut_ff == $past(portWrData))
    else $error("port latch wrong");
  a_soft_keeps: assert property (softReset && !portWr |=> $stable(firstPortOut_ff))
    else $error("soft reset touched a latch");
  a_flag_sticky: assert property (firstIrqFlag_ff && !irqClear |=> firstIrqFlag_ff)
    else $error("flag dropped without clear");
  a_off_quiet: assert property (cfg_ff[1:0] == 2'h0 && !irqCfgWr && !firstIrqFlag_ff |=> !firstIrqFlag_ff)
    else $error("disabled source set its flag");
  a_rise_flags: assert property (cfg_ff[1:0] == 2'h1 && !irqCfgWr && $rose(firstEventIn) |-> ##[1:3] firstIrqFlag_ff)
    else $error("rising edge not flagged");
  a_req_or: assert property (irqReq == (firstIrqFlag_ff || secondIrqFlag_ff))
    else $error("request not the flags");
  a_gen_load: assert property (genLoad |=> genCount == $past(genValue))
    else $error("count not loaded");
  a_gen_frozen: assert property (genStop && !genLoad ##1 !genLoad |=> $stable(genCount))
    else $error("stopped counter moved");
endmodule // dpg_group_assertions
bind dpg_port_group dpg_group_assertions #(.CW(CW)) chk (.ref_clk, .rst, .setupWr, .setupCode, .softReset,
  .dirIn_ff, .portWr, .portSel, .portWrData, .firstPortOut_ff, .firstPortOe, .splitPortOe, .irqCfgWr, .irqCfg,
  .irqClear, .firstEventIn, .firstIrqFlag_ff, .secondIrqFlag_ff, .irqReq, .genLoad, .genValue, .genStop, .genCount);
`default_nettype wire

// file: tb/dpg_line_model.sv
// Purpose: outside lines of one 8-bit port
// Assumes: releaseMask bit 1 leaves that line to the outside
// Notes:   released lines are always driven, so none floats
`timescale 1ns/1ns
`default_nettype none
module dpg_line_model (
  // group side
  input  wire logic [7:0] outVal,
  input  wire logic [7:0] releaseMask,
  // outside world
  input  wire logic [7:0] drive,
  output wire logic [7:0] lineIn
);
  assign lineIn = (outVal & ~releaseMask) | (drive & releaseMask);
endmodule // dpg_line_model
`default_nettype wire

// file: tb/digital_port_group_control_test.sv
// Purpose: self-checking bench for the port group
// Assumes: inputs change 5 ns after the rising edge
// Notes:   strobe tasks except load idle one cycle afterwards
`timescale 1ns/1ns
`default_nettype none
module digital_port_group_control_test;
  // ==========================================
  // wiring
  logic        ref_clk = 1'h0, rst = 1'h1, setupWr = 1'h0, softReset = 1'h0, portWr = 1'h0;
  logic        irqCfgWr = 1'h0, irqClear = 1'h0, firstEventIn = 1'h0, secondEventIn = 1'h0;
  logic        genLoad = 1'h0, genStop = 1'h0, genTick = 1'h0, chainStart = 1'h0, chainTick = 1'h0;
  logic [3:0]  setupCode = 4'h0, irqCfg = 4'h0;
  logic [1:0]  portSel = 2'h0;
  logic [7:0]  portWrData = 8'h00, drv = 8'h00;
  logic [2:0]  genMode = 3'h0;
  logic [15:0] genValue = 16'h0000, chainDivisorLo = 16'h0002, chainDivisorHi = 16'h0003, held;
  wire logic [3:0]  dirIn_ff;
  wire logic [7:0]  portRdData_ff, firstPortOut_ff, secondPortOut_ff, splitPortOut_ff;
  wire logic [7:0]  firstPortOe, secondPortOe, splitPortOe, firstPortIn, secondPortIn, splitPortIn;
  wire logic        firstIrqFlag_ff, secondIrqFlag_ff, irqReq, genOut, chainOut;
  wire logic [15:0] genCount;
  int          n_errors = 0, n_compared = 0, i;
  dpg_port_group #(.CW(16)) uut (.*);
  dpg_line_model la (.outVal(firstPortOut_ff), .releaseMask(firstPortOe), .drive(drv), .lineIn(firstPortIn));
  dpg_line_model lb (.outVal(secondPortOut_ff), .releaseMask(secondPortOe), .drive(drv), .lineIn(secondPortIn));
  dpg_line_model lc (.outVal(splitPortOut_ff), .releaseMask(splitPortOe), .drive(drv), .lineIn(splitPortIn));
  always #50 ref_clk = ~ref_clk;
  // ==========================================
  // shared tasks
  task tick; @(posedge ref_clk); #5; endtask
  task check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task close_out;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task set_dir(input logic [3:0] c);
    setupCode = c; setupWr = 1'h1; tick; setupWr = 1'h0; tick;
  endtask
  task wr_port(input logic [1:0] s, input logic [7:0] d);
    portSel = s; portWrData = d; portWr = 1'h1; tick; portWr = 1'h0; tick;
  endtask
  task rd_port(input logic [1:0] s, input logic [7:0] e);
    portSel = s; tick; tick;
    check(portRdData_ff === e, "port read");
  endtask
  task irq_cfg(input logic [3:0] c);
    irqCfg = c; irqCfgWr = 1'h1; tick; irqCfgWr = 1'h0; tick;
  endtask
  task clr; irqClear = 1'h1; tick; irqClear = 1'h0; tick; endtask
  task load(input logic [2:0] m, input logic [15:0] v);
    genMode = m; genValue = v; genLoad = 1'h1; tick; genLoad = 1'h0;
  endtask
  // ==========================================
  // scenarios
  task t_dirs;
    for (int c = 0; c < 16; c++) begin
      set_dir(c[3:0]);
      check(dirIn_ff === c[3:0] && firstPortOe === {8{c[3]}} && secondPortOe === {8{c[1]}}
            && splitPortOe === {{4{c[2]}}, {4{c[0]}}}, "direction code");
    end
  endtask
  task t_soft;
    set_dir(4'h0);
    wr_port(2'h0, 8'ha5);
    setupCode = 4'h0; setupWr = 1'h1; softReset = 1'h1; tick; setupWr = 1'h0; softReset = 1'h0; tick;
    check(dirIn_ff === 4'hf && firstPortOe === 8'hff && splitPortOe === 8'hff, "soft reset dirs");
    check(firstPortOut_ff === 8'ha5, "soft reset latch");
  endtask
  task t_data;
    set_dir(4'h0);
    wr_port(2'h0, 8'h96);
    rd_port(2'h0, 8'h96);
    wr_port(2'h2, 8'h5a);
    wr_port(2'h1, 8'hc3);
    check(secondPortOut_ff === 8'hc3 && splitPortOut_ff === 8'h5a, "port latches");
    set_dir(4'h6);
    drv = 8'h3c;
    rd_port(2'h2, 8'h3a);
    rd_port(2'h1, 8'h3c);
    rd_port(2'h3, 8'h3a);
  endtask
  task t_irq;
    irq_cfg(4'h0);
    firstEventIn = 1'h1; secondEventIn = 1'h1; repeat (3) tick; firstEventIn = 1'h0; secondEventIn = 1'h0; tick;
    check(firstIrqFlag_ff === 1'h0 && secondIrqFlag_ff === 1'h0, "disabled flag");
    irq_cfg(4'h5);
    firstEventIn = 1'h1; repeat (3) tick;
    check(firstIrqFlag_ff === 1'h1 && secondIrqFlag_ff === 1'h0, "first rise");
    secondEventIn = 1'h1; repeat (6) tick;
    check(firstIrqFlag_ff === 1'h1 && secondIrqFlag_ff === 1'h1 && irqReq === 1'h1, "sticky flags");
    clr;
    check(firstIrqFlag_ff === 1'h0 && secondIrqFlag_ff === 1'h0 && irqReq === 1'h0, "clear");
    irq_cfg(4'ha);
    firstEventIn = 1'h0; secondEventIn = 1'h0; repeat (3) tick;
    check(firstIrqFlag_ff === 1'h1 && secondIrqFlag_ff === 1'h1, "falling mode");
    clr;
  endtask
  task t_gen;
    for (int m = 0; m < 6; m++) begin
      load(m[2:0], 16'h0004);
      check(genCount === 16'h0004, "load");
      genTick = 1'h1; tick; genTick = 1'h0; tick;
      check(genCount === 16'h0003, "count step");
    end
    genTick = 1'h1; tick; genStop = 1'h1; tick; genStop = 1'h0; held = genCount; repeat (3) tick; genTick = 1'h0;
    check(genCount === held, "frozen");
    irq_cfg(4'h3);
    load(3'h0, 16'h0002); genTick = 1'h1; repeat (4) tick; genTick = 1'h0; tick;
    check(firstIrqFlag_ff === 1'h1 && genOut === 1'h1, "counter source");
    clr;
  endtask
  task t_chain;
    irq_cfg(4'hc);
    chainTick = 1'h1; repeat (20) tick;
    check(secondIrqFlag_ff === 1'h0 && chainOut === 1'h0, "chain idle");
    chainStart = 1'h1; tick; chainStart = 1'h0;
    for (i = 0; i < 40 && secondIrqFlag_ff !== 1'h1; i++) tick;
    check(secondIrqFlag_ff === 1'h1 && i > 3 && chainOut === 1'h1, "chain rate");
    // clear takes two cycles, so the next request lands after lo*hi ticks
    clr;
    for (i = 0; i < 40 && secondIrqFlag_ff !== 1'h1; i++) tick;
    check(secondIrqFlag_ff === 1'h1 && i + 2 == chainDivisorLo * chainDivisorHi, "chain period");
    chainTick = 1'h0;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #5 rst = 1'h0;
    tick;
    t_dirs;
    t_soft;
    t_data;
    t_irq;
    t_gen;
    t_chain;
    close_out;
  end
  initial begin
    #2000000;
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    close_out;
  end
endmodule // digital_port_group_control_test
`default_nettype wire
